// >>> rtl/pss_core.sv
// Program sequencer: phases, fetch/execute pipeline, program counter, ALU and APB registers
// Operation
// - Each instruction cycle consists of four successive clock phases.
// - Phase one increments the counter and fetches; phases two to four execute.
// - Fetch overlaps execution, so plain instructions take one instruction cycle.
// - Jumps and calls take two cycles: target, then the branch itself.
// - A taken skip discards the prefetched word and runs a dummy cycle.
// - Program counter is 11 bits; its low byte has its own register, and all 11 bits read back in the status word.
// - Low byte is read/write; writing it jumps within the current 256-word page.
// - A low-byte write inserts one dummy cycle refetching from the new address.
// - Jumps, calls, interrupts and reset load the counter instead of incrementing.
// - Four-level stack holds counter values only, invisible to software.
// - Calls and interrupt acknowledges push the counter value less one, the return address.
// - Return and interrupt return pop the stack into the counter.
// - Reset leaves the stack pointer at the top, the empty state.
// - Interrupt with full stack stays pending until a return frees a level.
// - Call on a full stack proceeds; the oldest saved value is lost.
// - Eight-bit ALU works on the accumulator and the immediate byte, result back into the accumulator.
// - ALU operations update carry, borrow and other status flags.
// - ALU adds, subtracts, adjusts decimal, does logic, rotates, increments, decrements.
// - Execution starts at program address zero after reset.
// - Program memory holds 2K words of 16 bits.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "pss_map.svh"
module pss_core #(
  parameter int AW = 8,
  parameter int PC_W = `PSS_PC_W,
  parameter int IW = 16,
  parameter int STACK_DEPTH = `PSS_STACK_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [IW-1:0] pmem_rdata,
  output logic pmem_rd,
  input wire logic irq_req,
  output logic [3:0] instruction_phases,
  output logic int_ack
);

  localparam int CW = $clog2(STACK_DEPTH + 1);

  // ==========================================================
  // ALU
  function automatic logic [11:0] pss_alu(input pss_pkg::pss_op_t op, input logic [7:0] a,
                                          input logic [7:0] b, input logic [3:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic c;
    logic ac;
    logic ov;
    logic z;
    logic cin;
    s = 9'h000;
    h = 5'h00;
    r = a;
    c = f[0];
    ac = f[1];
    z = f[2];
    ov = f[3];
    cin = 1'b0;
    case (op)
      `PSS_OP_ADD, `PSS_OP_ADC:
      begin
        cin = (op == `PSS_OP_ADC) & f[0];
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r = s[7:0];
        c = s[8];
        ac = h[4];
        ov = (a[7] == b[7]) & (r[7] != a[7]);
      end
      `PSS_OP_SUB, `PSS_OP_SBC:
      begin
        // Carry set means no borrow
        cin = (op == `PSS_OP_SUB) | f[0];
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        r = s[7:0];
        c = s[8];
        ac = h[4];
        ov = (a[7] != b[7]) & (r[7] != a[7]);
      end
      `PSS_OP_DAA:
      begin
        s = {1'b0, a};
        if (a[3:0] > 4'h9 || f[1])
          s = s + 9'h006;
        if (s[7:4] > 4'h9 || f[0] || s[8])
          s = s + 9'h060;
        r = s[7:0];
        c = f[0] | s[8];
      end
      `PSS_OP_AND: r = a & b;
      `PSS_OP_OR: r = a | b;
      `PSS_OP_XOR: r = a ^ b;
      `PSS_OP_CPL: r = ~a;
      `PSS_OP_RR: r = {a[0], a[7:1]};
      `PSS_OP_RRC:
      begin
        r = {f[0], a[7:1]};
        c = a[0];
      end
      `PSS_OP_RL: r = {a[6:0], a[7]};
      `PSS_OP_RLC:
      begin
        r = {a[6:0], f[0]};
        c = a[7];
      end
      `PSS_OP_INC: r = a + 8'h01;
      `PSS_OP_DEC: r = a - 8'h01;
      default: r = b;
    endcase
    // Rotations, plain or through carry, leave zero untouched
    if (op != `PSS_OP_RR && op != `PSS_OP_RL && op != `PSS_OP_RRC && op != `PSS_OP_RLC)
      z = (r == 8'h00);
    return {ov, z, ac, c, r};
  endfunction : pss_alu

  // ==========================================================
  // State
  pss_pkg::pss_phase_t phase_r;
  pss_pkg::pss_flags_t flags_r;
  logic [PC_W-1:0] pc_r;
  logic [IW-1:0] fetch_r;
  logic [IW-1:0] exec_r;
  logic flush_r;
  logic [7:0] acc_r;
  logic [1:0] ctrl_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic irq_s3_r;
  logic pend_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  pss_stk_if #(.AW(PC_W), .CW(CW)) stk ();

  pss_stack #(.AW(PC_W), .DEPTH(STACK_DEPTH), .CW(CW)) u_stack (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .stk(stk)
  );

  // ==========================================================
  // Decode
  wire running = ctrl_r[`PSS_CTRL_RUN];
  wire at_t1 = running && (phase_r == pss_pkg::PSS_T1);
  wire at_t4 = running && (phase_r == pss_pkg::PSS_T4);
  wire [3:0] cls = exec_r[15:12];
  wire [3:0] aop = exec_r[11:8];
  wire [7:0] imm = exec_r[7:0];
  wire [PC_W-1:0] target = exec_r[PC_W-1:0];
  wire [PC_W-1:0] ret_pc = pc_r - PC_W'(1);
  wire [11:0] alu_out = pss_alu(aop, acc_r, imm, flags_r);
  wire is_alu = (cls == `PSS_CL_ALU);
  wire is_jmp = (cls == `PSS_CL_JMP);
  wire is_call = (cls == `PSS_CL_CALL);
  wire is_ret = (cls == `PSS_CL_RET) || (cls == `PSS_CL_INTERRUPT_RETURN);
  wire is_pclw = (cls == `PSS_CL_PCLW);
  wire skip_hit = ((cls == `PSS_CL_SZ) && acc_r == 8'h00) || ((cls == `PSS_CL_SNZ) && acc_r != 8'h00);
  wire redirect = is_jmp || is_call || is_ret || is_pclw || skip_hit;
  wire irq_edge = irq_s2_r && !irq_s3_r;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_pcl = (paddr == `PSS_OFF_PCL);
  wire hit_ctrl = (paddr == `PSS_OFF_CTRL);
  wire hit_stat = (paddr == `PSS_OFF_STAT);
  wire hit_acc = (paddr == `PSS_OFF_ACC);
  wire hit_any = hit_pcl || hit_ctrl || hit_stat || hit_acc;
  wire sw_pcl = apb_wr && hit_pcl;
  wire sw_ctrl = apb_wr && hit_ctrl;
  wire sw_acc = apb_wr && hit_acc;
  // Software counter write in the same edge wins over execute-phase work
  wire t4_live = at_t4 && !sw_pcl;
  wire int_take = t4_live && pend_r && ctrl_r[`PSS_CTRL_INTEN] && !stk.full && !redirect;
  logic [31:0] stat_word;

  // Status word, fields placed at their map positions
  always_comb
  begin
    stat_word = 32'h00000000;
    stat_word[PC_W-1:0] = pc_r;
    stat_word[`PSS_STAT_DEPTH_LSB +: 3] = stk.depth[2:0];
    stat_word[`PSS_STAT_FULL] = stk.full;
    stat_word[`PSS_STAT_PEND] = pend_r;
    stat_word[`PSS_STAT_FLAG_LSB +: 4] = flags_r;
  end
  wire [31:0] rd_mux = hit_pcl ? {24'h000000, pc_r[7:0]} :
                       hit_ctrl ? {30'h00000000, ctrl_r} :
                       hit_stat ? stat_word :
                       hit_acc ? {24'h000000, acc_r} : 32'h00000000;

  assign stk.push = (t4_live && is_call) || int_take;
  assign stk.pop = t4_live && is_ret;
  assign stk.push_pc = ret_pc;

  assign pmem_addr = pc_r;
  assign pmem_rd = at_t1;
  assign int_ack = int_take;
  assign instruction_phases = running ? (4'h1 << phase_r) : 4'h0;
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;

  // ==========================================================
  // Phase sequencer
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_r <= pss_pkg::PSS_T1;
    else if (running)
      phase_r <= pss_pkg::pss_phase_t'(phase_r + 2'h1);
  end

  // ==========================================================
  // Fetch and execute pipeline
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_r <= `PSS_PC_RST;
      fetch_r <= `PSS_NOP_WORD;
      exec_r <= `PSS_NOP_WORD;
      flush_r <= 1'b1;
    end
    else if (sw_pcl)
    begin
      pc_r <= {pc_r[PC_W-1:8], pwdata[7:0]};
      // Instruction in flight is dropped, else a later branch would undo the write
      exec_r <= `PSS_NOP_WORD;
      flush_r <= 1'b1;
    end
    else if (at_t1)
    begin
      fetch_r <= pmem_rdata;
      exec_r <= flush_r ? `PSS_NOP_WORD : fetch_r;
      pc_r <= pc_r + PC_W'(1);
      flush_r <= 1'b0;
    end
    else if (at_t4)
    begin
      if (int_take)
      begin
        pc_r <= `PSS_INT_VEC;
        flush_r <= 1'b1;
      end
      else if (is_jmp || is_call)
      begin
        pc_r <= target;
        flush_r <= 1'b1;
      end
      else if (is_ret)
      begin
        pc_r <= stk.top_pc;
        flush_r <= 1'b1;
      end
      else if (is_pclw)
      begin
        pc_r <= {pc_r[PC_W-1:8], acc_r};
        flush_r <= 1'b1;
      end
      else if (skip_hit)
        flush_r <= 1'b1;
    end
  end

  // ==========================================================
  // Accumulator and status
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_r <= 8'h00;
      flags_r <= '0;
    end
    else if (sw_acc)
      acc_r <= pwdata[7:0];
    else if (t4_live && is_alu)
    begin
      acc_r <= alu_out[7:0];
      flags_r <= alu_out[11:8];
    end
    else if (t4_live && cls == `PSS_CL_PCLR)
      acc_r <= pc_r[7:0];
  end

  // ==========================================================
  // Control and interrupt pending
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= `PSS_CTRL_RST;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      irq_s3_r <= 1'b0;
      pend_r <= 1'b0;
    end
    else
    begin
      irq_s1_r <= irq_req;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      // New request wins over the acknowledge clear
      if (irq_edge)
        pend_r <= 1'b1;
      else if (int_take)
        pend_r <= 1'b0;
      if (sw_ctrl)
        ctrl_r <= pwdata[1:0];
      else if (int_take)
        ctrl_r[`PSS_CTRL_INTEN] <= 1'b0;
      else if (t4_live && cls == `PSS_CL_INTERRUPT_RETURN)
        ctrl_r[`PSS_CTRL_INTEN] <= 1'b1;
    end
  end

  // ==========================================================
  // APB read data, captured in the setup cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_r <= !hit_any;
    end
  end

endmodule : pss_core

// >>> rtl/pss_map.svh
// Offsets, field positions, reset values, encodings and counts of the program sequencer
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PSS_OFF_PCL 8'h00
`define PSS_OFF_CTRL 8'h04
`define PSS_OFF_STAT 8'h08
`define PSS_OFF_ACC 8'h0C

// ==========================================================
// Control and status fields
`define PSS_CTRL_RUN 0
`define PSS_CTRL_INTEN 1
`define PSS_CTRL_RST 2'h0
`define PSS_STAT_DEPTH_LSB 12
`define PSS_STAT_FULL 15
`define PSS_STAT_PEND 16
`define PSS_STAT_FLAG_LSB 17

// ==========================================================
// Program counter and vectors
`define PSS_PC_W 11
`define PSS_PC_RST 11'h000
`define PSS_INT_VEC 11'h004
`define PSS_STACK_DEPTH 4
`define PSS_PHASES 4

// ==========================================================
// Instruction classes, word bits [15:12]
`define PSS_CL_NOP 4'h0
`define PSS_CL_ALU 4'h1
`define PSS_CL_JMP 4'h2
`define PSS_CL_CALL 4'h3
`define PSS_CL_RET 4'h4
`define PSS_CL_INTERRUPT_RETURN 4'h5
`define PSS_CL_SZ 4'h6
`define PSS_CL_SNZ 4'h7
`define PSS_CL_PCLW 4'h8
`define PSS_CL_PCLR 4'h9
`define PSS_NOP_WORD 16'h0000

// ==========================================================
// ALU operations, word bits [11:8]
`define PSS_OP_ADD 4'h0
`define PSS_OP_ADC 4'h1
`define PSS_OP_SUB 4'h2
`define PSS_OP_SBC 4'h3
`define PSS_OP_DAA 4'h4
`define PSS_OP_AND 4'h5
`define PSS_OP_OR 4'h6
`define PSS_OP_XOR 4'h7
`define PSS_OP_CPL 4'h8
`define PSS_OP_RR 4'h9
`define PSS_OP_RRC 4'hA
`define PSS_OP_RL 4'hB
`define PSS_OP_RLC 4'hC
`define PSS_OP_INC 4'hD
`define PSS_OP_DEC 4'hE
`define PSS_OP_MOV 4'hF

`endif

// >>> rtl/pss_pkg.sv
// Types shared by the program sequencer modules
package pss_pkg;

  // ==========================================================
  // Instruction phase within one instruction cycle
  typedef enum logic [1:0] {PSS_T1, PSS_T2, PSS_T3, PSS_T4} pss_phase_t;

  // ==========================================================
  // Status flags
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pss_flags_t;

  typedef logic [3:0] pss_op_t;

endpackage : pss_pkg

// >>> rtl/pss_stack.sv
// Return-address stack, circular, oldest entry overwritten on overflow
`timescale 1ns/1ns
module pss_stack #(
  parameter int AW = 11,
  parameter int DEPTH = 4,
  parameter int CW = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  pss_stk_if.stack stk
);

  localparam int PW = $clog2(DEPTH);

  // Depth must be a power of two so the pointer wraps by itself
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_r;
  logic [CW-1:0] cnt_r;
  logic [PW-1:0] top_idx;
  logic at_full;

  assign top_idx = wptr_r - {{(PW-1){1'b0}}, 1'b1};
  assign at_full = (cnt_r == CW'(DEPTH));
  assign stk.top_pc = mem[top_idx];
  assign stk.depth = cnt_r;
  assign stk.full = at_full;

  // ==========================================================
  // Pointer and level count, empty after reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr_r <= '0;
      cnt_r <= '0;
    end
    else if (stk.push)
    begin
      wptr_r <= wptr_r + {{(PW-1){1'b0}}, 1'b1};
      if (!at_full)
        cnt_r <= cnt_r + CW'(1);
    end
    else if (stk.pop && cnt_r != '0)
    begin
      wptr_r <= top_idx;
      cnt_r <= cnt_r - CW'(1);
    end
  end

  // Full push lands on the oldest slot, which is thereby lost
  always_ff @(posedge core_clk)
  begin
    if (stk.push)
      mem[wptr_r] <= stk.push_pc;
  end

endmodule : pss_stack

// >>> rtl/pss_stk_if.sv
// Carrier between the sequencer core and its return-address stack
`timescale 1ns/1ns
interface pss_stk_if #(parameter int AW = 11, parameter int CW = 3);
  logic push;
  logic pop;
  logic [AW-1:0] push_pc;
  logic [AW-1:0] top_pc;
  logic [CW-1:0] depth;
  logic full;

  modport core (output push, output pop, output push_pc, input top_pc, input depth, input full);
  modport stack (input push, input pop, input push_pc, output top_pc, output depth, output full);
endinterface : pss_stk_if

// >>> sim/pss_core_asserts.sv
// Concurrent checks on the sequencer's ports
`timescale 1ns/1ns
module pss_core_asserts #(
  parameter int AW = 8,
  parameter int PC_W = 11,
  parameter int IW = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic [IW-1:0] pmem_rdata,
  input wire logic pmem_rd,
  input wire logic irq_req,
  input wire logic [3:0] instruction_phases,
  input wire logic int_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire bus_wr = psel && penable && pwrite;
  property p_onehot; $onehot0(instruction_phases); endproperty
  a_onehot: assert property (p_onehot) else $error("phase not one-hot");
  property p_walk; instruction_phases == 4'h1 |=> instruction_phases == 4'h2 ##1 instruction_phases == 4'h4
    ##1 instruction_phases == 4'h8; endproperty
  a_walk: assert property (p_walk) else $error("phase order broken");
  property p_fetch; pmem_rd == instruction_phases[0]; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch outside first phase");
  property p_inc; instruction_phases == 4'h1 && !bus_wr |=> pmem_addr == $past(pmem_addr) + 11'h001; endproperty
  a_inc: assert property (p_inc) else $error("counter not incremented");
  // Mid-cycle phases must leave the counter alone
  property p_hold; (instruction_phases == 4'h2 || instruction_phases == 4'h4) && !bus_wr |=> $stable(pmem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved mid-cycle");
  property p_lowwr; bus_wr && paddr == 8'h00 |=> pmem_addr[10:8] == $past(pmem_addr[10:8])
    && pmem_addr[7:0] == $past(pwdata[7:0]); endproperty
  a_lowwr: assert property (p_lowwr) else $error("low byte write jump wrong");
  property p_lowrd; psel && !penable && !pwrite && paddr == 8'h00 |=> prdata[7:0] == $past(pmem_addr[7:0]);
  endproperty
  a_lowrd: assert property (p_lowrd) else $error("low byte read wrong");
  property p_ackph; int_ack |-> instruction_phases == 4'h8; endproperty
  a_ackph: assert property (p_ackph) else $error("acknowledge off last phase");
  property p_vec; int_ack && !bus_wr |=> pmem_addr == 11'h004; endproperty
  a_vec: assert property (p_vec) else $error("vector not loaded");
  property p_rst; $rose(reset_n) |-> pmem_addr == 11'h000; endproperty
  a_rst: assert property (p_rst) else $error("start address not zero");
endmodule : pss_core_asserts

bind pss_core pss_core_asserts #(.AW(AW), .PC_W(PC_W), .IW(IW)) u_chk (.core_clk(core_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
  .pmem_rd(pmem_rd), .irq_req(irq_req), .instruction_phases(instruction_phases), .int_ack(int_ack));

// >>> sim/pss_pmem_model.sv
// Program memory model for the sequencer's fetch port
`timescale 1ns/1ns
module pss_pmem_model (
  input wire logic core_clk,
  input wire logic [10:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [15:0] pmem_rdata
);
  logic [15:0] mem [0:2047];
  logic [15:0] junk_r = 16'hA5A5;
  // Outside a fetch the bus shows no stale word
  always @(posedge core_clk) junk_r <= ~junk_r;
  assign pmem_rdata = pmem_rd ? mem[pmem_addr] : junk_r;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
endmodule : pss_pmem_model

// >>> sim/tb_top.sv
// Register-level regression of the program sequencer
`timescale 1ns/1ns
`include "pss_map.svh"
module tb_top;
  localparam logic [7:0] PC_LOW = 8'h00;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic irq_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pmem_rd, int_ack, er;
  logic [10:0] pmem_addr;
  logic [15:0] pmem_rdata;
  logic [3:0] instruction_phases;
  int mismatches = 0;
  int n_checks = 0;
  int n_ack = 0;
  // op, operand a, operand b, result, {c,z}; carry chains row to row
  logic [31:0] alu_tab [0:15] = '{32'h0F020102, 32'h10101030, 32'h41A00200, 32'h20505003, 32'h30501042,
    32'h5F03C302, 32'h60000003, 32'h7FFFF003, 32'h80F00F02, 32'h90100802, 32'hA0200810, 32'hB8000010,
    32'hC8000002, 32'hDFF00003, 32'hE0100003, 32'hF1234342};

  pss_core uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .pmem_rd(pmem_rd), .irq_req(irq_req),
    .instruction_phases(instruction_phases), .int_ack(int_ack));
  pss_pmem_model pmem (.core_clk(core_clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (int_ack === 1'b1) n_ack++;

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    if (n >= 20)
    begin
      mismatches++;
      final_report;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msk);
  endtask : rdc

  initial
  begin
    #1000000;
    mismatches++;
    final_report;
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdc(`PSS_OFF_STAT, 32'h0, 32'hFFFFFFFF);
    rdc(8'h10, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1, 32'h1);
    $display("reset test done");
    pmem.mem[11'h011] = 16'h2011;
    wr(`PSS_OFF_CTRL, 32'h1);
    foreach (alu_tab[i])
    begin
      pmem.mem[11'h010] = {4'h1, alu_tab[i][31:28], alu_tab[i][19:12]};
      wr(`PSS_OFF_ACC, {24'h0, alu_tab[i][27:20]});
      wr(PC_LOW, 32'h10);
      repeat (16) @(posedge core_clk);
      rdc(`PSS_OFF_ACC, {24'h0, alu_tab[i][11:4]}, 32'hFF);
      rdc(`PSS_OFF_STAT, {12'h0, alu_tab[i][0], 1'b0, alu_tab[i][1], 17'h0}, 32'h000A0000);
    end
    $display("alu test done");
    pmem.mem[11'h020] = 16'h3030;
    pmem.mem[11'h021] = 16'h1F5A;
    pmem.mem[11'h022] = 16'h2022;
    pmem.mem[11'h030] = 16'h4000;
    wr(PC_LOW, 32'h20);
    // Up to four clocks to the first fetch, then seven instruction cycles
    repeat (32) @(posedge core_clk);
    rdc(`PSS_OFF_ACC, 32'h5A, 32'hFF);
    rdc(`PSS_OFF_STAT, 32'h0, 32'hF000);
    rdc(PC_LOW, 32'h22, 32'hFE);
    $display("call test done");
    for (int k = 0; k < 2; k++)
    begin
      pmem.mem[11'h060] = {4'h6 + 4'(k), 12'h000};
      pmem.mem[11'h061] = 16'h1F11;
      pmem.mem[11'h062] = 16'h1001;
      pmem.mem[11'h063] = 16'h2063;
      wr(`PSS_OFF_ACC, 32'h0);
      wr(PC_LOW, 32'h60);
      repeat (28) @(posedge core_clk);
      rdc(`PSS_OFF_ACC, k ? 32'h12 : 32'h01, 32'hFF);
    end
    $display("skip test done");
    // Five nested calls: the first return address must be lost
    pmem.mem[11'h040] = 16'h3050;
    pmem.mem[11'h041] = 16'h1F77;
    pmem.mem[11'h042] = 16'h2042;
    for (int a = 11'h050; a < 11'h054; a++) pmem.mem[a] = 16'h3000 + 16'(a + 1);
    pmem.mem[11'h054] = 16'h2054;
    pmem.mem[11'h055] = 16'h4000;
    pmem.mem[11'h004] = 16'h2004;
    pmem.mem[11'h005] = 16'h5000;
    wr(`PSS_OFF_CTRL, 32'h3);
    wr(`PSS_OFF_ACC, 32'h0);
    wr(PC_LOW, 32'h40);
    repeat (48) @(posedge core_clk);
    rdc(`PSS_OFF_STAT, 32'h0000C000, 32'h0001F000);
    irq_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    rdc(`PSS_OFF_STAT, 32'h0001C000, 32'h0001F000);
    chk(n_ack, 32'h0, 32'hFFFFFFFF);
    wr(PC_LOW, 32'h55);
    repeat (30) @(posedge core_clk);
    chk(n_ack, 32'h1, 32'hFFFFFFFF);
    rdc(`PSS_OFF_STAT, 32'h0000C000, 32'h0001F000);
    rdc(`PSS_OFF_CTRL, 32'h1, 32'h3);
    irq_req <= 1'b0;
    for (int a = 11'h051; a < 11'h055; a++) pmem.mem[a] = 16'h4000;
    wr(PC_LOW, 32'h05);
    repeat (64) @(posedge core_clk);
    rdc(`PSS_OFF_STAT, 32'h0, 32'hF000);
    rdc(`PSS_OFF_ACC, 32'h0, 32'hFF);
    $display("stack test done");
    // Reset in mid-run must clear counter, stack and flags
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdc(`PSS_OFF_STAT, 32'h0, 32'hFFFFFFFF);
    $display("second reset test done");
    final_report;
  end
endmodule : tb_top
